// ==== core/mpf_pkg.sv ====
//==============================================================
// Contract
// - Signed multiply writes 16-bit product to R1:R0, updates Z and C, 2 cycles.
// - Mixed multiply: first operand signed, second unsigned, R1:R0, Z and C, 2 cycles.
// - Fractional multiplies shift product left one bit into R1:R0, Z and C, 2 cycles.
// - Relative jump/call loads PC+offset+1, no flags; jump 2, call 3 cycles.
// - Pointer jump loads PC from Z pointer, no flags, 2 cycles.
// - Pointer call saves return address, loads PC from Z, no flags, 3 cycles.
// - Absolute jump loads PC with instruction address, no flags, 3 cycles.
// - Absolute call saves return address, loads PC with address, no flags, 4 cycles.
// - Subroutine return restores PC from stack, no flags, 4 cycles.
// - Interrupt return restores PC from stack, sets global interrupt enable, 4 cycles.
package mpf_pkg;

  //==============================================================
  // Operations and constants
  typedef enum logic [3:0] {
    OP_MUL_SIGNED = 4'h0,
    OP_MUL_SIGNED_BY_UNSIGNED = 4'h1,
    OP_FRAC_MUL_UNSIGNED = 4'h2,
    OP_FRAC_MUL_SIGNED = 4'h3,
    OP_FRAC_MUL_MIXED = 4'h4,
    OP_REL_JUMP = 4'h5,
    OP_PTR_JUMP = 4'h6,
    OP_ABS_JUMP = 4'h7,
    OP_REL_CALL = 4'h8,
    OP_PTR_CALL = 4'h9,
    OP_ABS_CALL = 4'hA,
    OP_SUB_RETURN = 4'hB,
    OP_IRQ_RETURN = 4'hC
  } mpf_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } mpf_st_t;

  localparam logic [2:0] CYC_MUL = 3'h2;
  localparam logic [2:0] CYC_REL_JUMP = 3'h2;
  localparam logic [2:0] CYC_REL_CALL = 3'h3;
  localparam logic [2:0] CYC_PTR_JUMP = 3'h2;
  localparam logic [2:0] CYC_PTR_CALL = 3'h3;
  localparam logic [2:0] CYC_ABS_JUMP = 3'h3;
  localparam logic [2:0] CYC_ABS_CALL = 3'h4;
  localparam logic [2:0] CYC_RETURN = 3'h4;
  localparam logic [15:0] RET_SHORT = 16'h0001;
  localparam logic [15:0] RET_LONG = 16'h0002;
  localparam logic [15:0] REL_BIAS = 16'h0001;
  localparam int STACK_DEPTH = 16;

  //==============================================================
  // Carriers
  typedef struct packed {
    mpf_op_t op;
    logic [7:0] rd;
    logic [7:0] rr;
    logic [11:0] k;
    logic [15:0] absAddr;
    logic [15:0] zPtr;
    logic [15:0] pc;
  } mpf_req_t;

  typedef struct packed {
    logic pcLoad;
    logic [15:0] pc;
    logic prodWe;
    logic [15:0] prod;
    logic flagWe;
    logic zFlag;
    logic cFlag;
    logic gieSet;
  } mpf_res_t;

  typedef struct packed {
    mpf_st_t st;
    logic [2:0] cnt;
    logic done;
    mpf_req_t req;
    mpf_res_t res;
    logic [3:0] sp;
    logic [STACK_DEPTH-1:0][15:0] stk;
  } mpf_state_t;

  //==============================================================
  // Decoding
  function automatic logic [2:0] opCycles(input mpf_op_t op);
    unique case (op)
      OP_REL_JUMP: opCycles = CYC_REL_JUMP;
      OP_REL_CALL: opCycles = CYC_REL_CALL;
      OP_PTR_JUMP: opCycles = CYC_PTR_JUMP;
      OP_PTR_CALL: opCycles = CYC_PTR_CALL;
      OP_ABS_JUMP: opCycles = CYC_ABS_JUMP;
      OP_ABS_CALL: opCycles = CYC_ABS_CALL;
      OP_SUB_RETURN, OP_IRQ_RETURN: opCycles = CYC_RETURN;
      default: opCycles = CYC_MUL;
    endcase
  endfunction : opCycles

  function automatic logic isMul(input mpf_op_t op);
    isMul = (op <= OP_FRAC_MUL_MIXED);
  endfunction : isMul

  function automatic logic isCall(input mpf_op_t op);
    isCall = (op == OP_REL_CALL) || (op == OP_PTR_CALL) || (op == OP_ABS_CALL);
  endfunction : isCall

  function automatic logic isReturn(input mpf_op_t op);
    isReturn = (op == OP_SUB_RETURN) || (op == OP_IRQ_RETURN);
  endfunction : isReturn

endpackage : mpf_pkg

// ==== core/mpf_exec.sv ====
`timescale 1ns/1ps
`default_nettype none
module mpf_exec (
  input wire logic clk, // 40 MHz core clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic reqValid, // Decoded instruction offered
  input wire mpf_pkg::mpf_req_t req, // Instruction and operands
  output logic reqReady, // Idle, can take one
  output logic done, // One-cycle completion pulse
  output mpf_pkg::mpf_res_t res, // Results, held to next done
  output logic [3:0] stackPtr // Return stack depth in use
);
  import mpf_pkg::*;

  //==============================================================
  // State
  mpf_state_t s, n;
  logic signed [8:0] opA, opB;
  logic signed [17:0] prod18;
  logic [15:0] prod16, prodOut, retAddr, relTgt, popAddr;
  mpf_res_t resNow;

  //==============================================================
  // Datapath on the latched instruction
  always_comb
  begin
    opA = {s.req.op != OP_FRAC_MUL_UNSIGNED && s.req.rd[7], s.req.rd};
    opB = {(s.req.op == OP_MUL_SIGNED || s.req.op == OP_FRAC_MUL_SIGNED) && s.req.rr[7],
           s.req.rr};
    prod18 = opA * opB;
    prod16 = prod18[15:0];
    prodOut = (s.req.op >= OP_FRAC_MUL_UNSIGNED) ? {prod16[14:0], 1'b0} : prod16;
    retAddr = s.req.pc + ((s.req.op == OP_ABS_CALL) ? RET_LONG : RET_SHORT);
    relTgt = s.req.pc + {{4{s.req.k[11]}}, s.req.k} + REL_BIAS;
    popAddr = s.stk[s.sp - 4'h1];
    resNow = s.res;
    resNow.pcLoad = !isMul(s.req.op);
    resNow.prodWe = isMul(s.req.op);
    resNow.flagWe = isMul(s.req.op);
    resNow.gieSet = (s.req.op == OP_IRQ_RETURN);
    resNow.pc = s.res.pc;
    if (isMul(s.req.op))
    begin
      // Carry is the top bit before the fractional shift
      resNow.prod = prodOut;
      resNow.cFlag = prod16[15];
      resNow.zFlag = (prodOut == 16'h0000);
    end
    unique case (s.req.op)
      OP_REL_JUMP, OP_REL_CALL: resNow.pc = relTgt;
      OP_PTR_JUMP, OP_PTR_CALL: resNow.pc = s.req.zPtr;
      OP_ABS_JUMP, OP_ABS_CALL: resNow.pc = s.req.absAddr;
      OP_SUB_RETURN, OP_IRQ_RETURN: resNow.pc = popAddr;
      default: resNow.pc = s.res.pc;
    endcase
  end

  //==============================================================
  // Sequencer
  always_comb
  begin
    n = s;
    n.done = 1'b0;
    unique case (s.st)
      ST_IDLE:
        if (reqValid)
        begin
          n.st = ST_EXEC;
          n.req = req;
          n.cnt = opCycles(req.op) - 3'h1;
        end
      ST_EXEC:
        if (s.cnt == 3'h1)
        begin
          // Results and stack move together on the final edge
          n.st = ST_IDLE;
          n.done = 1'b1;
          n.res = resNow;
          if (isCall(s.req.op))
          begin
            // Deeper nesting than the stack silently overwrites the oldest entry
            n.stk[s.sp] = retAddr;
            n.sp = s.sp + 4'h1;
          end
          if (isReturn(s.req.op))
          begin
            n.sp = s.sp - 4'h1;
          end
        end
        else
        begin
          n.cnt = s.cnt - 3'h1;
        end
      // Illegal state codes recover to idle
      default: n.st = ST_IDLE;
    endcase
    if (sys_rst)
    begin
      n = '0;
      n.st = ST_IDLE;
    end
  end

  always_ff @(posedge clk)
  begin
    s <= n;
  end

  assign reqReady = (s.st == ST_IDLE);
  assign done = s.done;
  assign res = s.res;
  assign stackPtr = s.sp;

  //==============================================================
  // Checks
  logic accept;
  logic [15:0] refSS, refSU, refUU;
  assign accept = reqValid && reqReady;
  assign refSS = {{8{req.rd[7]}}, req.rd} * {{8{req.rr[7]}}, req.rr};
  assign refSU = {{8{req.rd[7]}}, req.rd} * {8'h00, req.rr};
  assign refUU = {8'h00, req.rd} * {8'h00, req.rr};

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence sTake(mpf_op_t o);
    accept && req.op == o;
  endsequence
  sequence sQuiet1;
    !done;
  endsequence

  AST_MUL_SIGNED_PROD: assert property (sTake(OP_MUL_SIGNED) |-> ##1 sQuiet1 ##1
    (done && res.prod == $past(refSS, 2) && res.cFlag == $past(refSS[15], 2) && !res.pcLoad))
    else $error("signed product wrong or late");
  AST_MIXED_PROD: assert property (sTake(OP_MUL_SIGNED_BY_UNSIGNED) |-> ##2
    (done && res.prod == $past(refSU, 2) && res.zFlag == ($past(refSU, 2) == 16'h0000)))
    else $error("mixed product wrong or late");
  AST_FRAC_SHIFT: assert property (sTake(OP_FRAC_MUL_UNSIGNED) |-> ##2
    (done && res.prod == {$past(refUU[14:0], 2), 1'b0} && res.cFlag == $past(refUU[15], 2)))
    else $error("fractional product not shifted");
  AST_REL_PC: assert property (sTake(OP_REL_CALL) |-> ##1 !done[*2] ##1
    (done && res.pc == $past(req.pc + {{4{req.k[11]}}, req.k} + 16'h0001, 3) && !res.flagWe))
    else $error("relative call target or timing wrong");
  AST_PTR_JUMP: assert property (sTake(OP_PTR_JUMP) |-> ##2
    (done && res.pcLoad && res.pc == $past(req.zPtr, 2) && $stable(stackPtr)))
    else $error("pointer jump wrong");
  AST_PTR_CALL: assert property (sTake(OP_PTR_CALL) |-> ##3
    (done && res.pc == $past(req.zPtr, 3) && stackPtr == $past(stackPtr) + 4'h1))
    else $error("pointer call wrong");
  AST_ABS_JUMP: assert property (sTake(OP_ABS_JUMP) |-> ##1 !done[*2] ##1
    (done && res.pc == $past(req.absAddr, 3)))
    else $error("absolute jump wrong");
  AST_ABS_CALL: assert property (sTake(OP_ABS_CALL) |-> ##1 !done[*3] ##1
    (done && res.pc == $past(req.absAddr, 4) && s.stk[stackPtr - 4'h1] == $past(req.pc, 4) + 16'h0002))
    else $error("absolute call wrong");
  AST_RET: assert property (sTake(OP_SUB_RETURN) |-> ##4
    (done && res.pc == $past(s.stk[stackPtr - 4'h1]) && !res.flagWe && !res.gieSet))
    else $error("return wrong");
  AST_IRQ_RETURN_GIE: assert property (sTake(OP_IRQ_RETURN) |-> ##4 (done && res.gieSet))
    else $error("interrupt return left enable clear");
  AST_PUSH_ADDR: assert property (sTake(OP_REL_CALL) |-> ##3
    (s.stk[stackPtr - 4'h1] == $past(req.pc, 3) + 16'h0001))
    else $error("call pushed wrong return address");

  //==============================================================
  // Timing, stack and flag checks per instruction class
  sequence sBusy3;
    (!reqReady)[*3];
  endsequence

  AST_MUL_SIGNED_ZERO: assert property (sTake(OP_MUL_SIGNED) |-> ##2
    (res.zFlag == ($past(refSS, 2) == 16'h0000) && res.prodWe && res.flagWe))
    else $error("signed multiply zero flag or write enables wrong");
  AST_MIXED_TIME: assert property (sTake(OP_MUL_SIGNED_BY_UNSIGNED) |=> sQuiet1)
    else $error("mixed multiply finished early");
  AST_MIXED_KEEP: assert property (sTake(OP_MUL_SIGNED_BY_UNSIGNED) |-> ##2
    (!res.pcLoad && res.pc == $past(res.pc) && $stable(stackPtr)))
    else $error("mixed multiply disturbed program flow");
  AST_FRAC_SIGNED: assert property (sTake(OP_FRAC_MUL_SIGNED) |-> ##2
    (done && res.prod == {$past(refSS[14:0], 2), 1'b0} && res.cFlag == $past(refSS[15], 2)))
    else $error("signed fractional product wrong");
  AST_FRAC_MIXED: assert property (sTake(OP_FRAC_MUL_MIXED) |-> ##2
    (done && res.prod == {$past(refSU[14:0], 2), 1'b0} && res.cFlag == $past(refSU[15], 2)))
    else $error("mixed fractional product wrong");

  AST_REL_JUMP: assert property (sTake(OP_REL_JUMP) |-> ##2
    (done && res.pcLoad && !res.flagWe && $stable(stackPtr) &&
     res.pc == $past(req.pc + {{4{req.k[11]}}, req.k} + 16'h0001, 2)))
    else $error("relative jump target or timing wrong");
  AST_FLOW_NO_FLAGS: assert property (done && s.req.op >= OP_REL_JUMP |->
    (res.pcLoad && !res.flagWe && !res.prodWe))
    else $error("flow instruction touched flags or product");
  AST_PTR_CALL_PUSH: assert property (sTake(OP_PTR_CALL) |-> ##3
    (s.stk[stackPtr - 4'h1] == $past(req.pc, 3) + 16'h0001 && !res.flagWe))
    else $error("pointer call pushed wrong return address");
  AST_ABS_JUMP_KEEP: assert property (sTake(OP_ABS_JUMP) |-> ##3
    (res.pcLoad && !res.prodWe && !res.flagWe && $stable(stackPtr)))
    else $error("absolute jump touched flags or stack");
  AST_ABS_CALL_BUSY: assert property (sTake(OP_ABS_CALL) |->
    ##1 sBusy3 ##1 reqReady)
    else $error("absolute call busy time wrong");

  AST_RET_TIME: assert property (sTake(OP_SUB_RETURN) |-> ##1 (!done)[*3])
    else $error("return finished early");
  AST_RET_POP: assert property (sTake(OP_SUB_RETURN) |-> ##4
    (stackPtr == $past(stackPtr) - 4'h1))
    else $error("return did not pop the stack");
  AST_IRQ_RETURN_TIME: assert property (sTake(OP_IRQ_RETURN) |-> ##1 (!done)[*3])
    else $error("interrupt return finished early");
  AST_IRQ_RETURN_PC: assert property (sTake(OP_IRQ_RETURN) |-> ##4
    (res.pc == $past(s.stk[stackPtr - 4'h1]) && !res.flagWe))
    else $error("interrupt return target wrong");
  AST_GIE_ONLY: assert property (done |->
    (res.gieSet == (s.req.op == OP_IRQ_RETURN)))
    else $error("interrupt enable set by wrong instruction");

  // Depth moves only on a completing call or return; reset edge excluded
  AST_STACK_HOLD: assert property (!done && !$past(sys_rst) |-> $stable(stackPtr))
    else $error("stack depth moved without completion");

endmodule : mpf_exec
`default_nettype wire

// ==== tb/mpf_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module mpf_tb_top;
  import mpf_pkg::*;
  typedef struct packed {
    mpf_op_t op;
    logic [7:0] rd;
    logic [7:0] rr;
    logic [11:0] k;
    logic [15:0] aa;
    logic [15:0] zp;
    logic [15:0] pc;
    logic [2:0] n;
    logic [15:0] want;
    logic [1:0] zc;
    logic [3:0] sp;
  } mpf_row_t;
  logic clk;
  logic sys_rst;
  logic reqValid;
  mpf_req_t req;
  logic reqReady;
  logic done;
  mpf_res_t res;
  logic [3:0] stackPtr;
  int failures = 0;
  int checksDone = 0;
  int cyc;
  logic isMulRow;
  mpf_row_t r;
  mpf_res_t e;
  // =======
  // Table: want is the product for multiplies, the new PC otherwise
  mpf_row_t rows [16] = '{
    '{OP_MUL_SIGNED, 8'h00, 8'h55, '0, '0, '0, '0, 3'h2, 16'h0000, 2'h2, 4'h0},
    '{OP_MUL_SIGNED, 8'hFF, 8'h02, '0, '0, '0, '0, 3'h2, 16'hFFFE, 2'h1, 4'h0},
    '{OP_MUL_SIGNED_BY_UNSIGNED, 8'hFF, 8'hFF, '0, '0, '0, '0, 3'h2, 16'hFF01, 2'h1, 4'h0},
    '{OP_FRAC_MUL_UNSIGNED, 8'hFF, 8'hFF, '0, '0, '0, '0, 3'h2, 16'hFC02, 2'h1, 4'h0},
    '{OP_FRAC_MUL_SIGNED, 8'hC0, 8'h40, '0, '0, '0, '0, 3'h2, 16'hE000, 2'h1, 4'h0},
    '{OP_FRAC_MUL_MIXED, 8'h80, 8'h80, '0, '0, '0, '0, 3'h2, 16'h8000, 2'h1, 4'h0},
    '{OP_REL_JUMP, '0, '0, 12'hFFF, '0, '0, 16'h0100, 3'h2, 16'h0100, '0, 4'h0},
    '{OP_PTR_JUMP, '0, '0, '0, '0, 16'h1234, 16'h0050, 3'h2, 16'h1234, '0, 4'h0},
    '{OP_ABS_JUMP, '0, '0, '0, 16'hBEEF, '0, 16'h0060, 3'h3, 16'hBEEF, '0, 4'h0},
    '{OP_PTR_CALL, '0, '0, '0, '0, 16'h3000, 16'h0200, 3'h3, 16'h3000, '0, 4'h1},
    '{OP_ABS_CALL, '0, '0, '0, 16'h4000, '0, 16'h0300, 3'h4, 16'h4000, '0, 4'h2},
    '{OP_REL_CALL, '0, '0, 12'h7FF, '0, '0, 16'hFFFF, 3'h3, 16'h07FF, '0, 4'h3},
    '{OP_SUB_RETURN, '0, '0, '0, '0, '0, 16'h0900, 3'h4, 16'h0000, '0, 4'h2},
    '{OP_IRQ_RETURN, '0, '0, '0, '0, '0, 16'h0A00, 3'h4, 16'h0302, '0, 4'h1},
    '{OP_SUB_RETURN, '0, '0, '0, '0, '0, 16'h0B00, 3'h4, 16'h0201, '0, 4'h0},
    '{OP_REL_JUMP, '0, '0, 12'h800, '0, '0, 16'h0010, 3'h2, 16'hF811, '0, 4'h0}
  };

  mpf_exec dut_u (
    .clk(clk),
    .sys_rst(sys_rst),
    .reqValid(reqValid),
    .req(req),
    .reqReady(reqReady),
    .done(done),
    .res(res),
    .stackPtr(stackPtr)
  );

  // =======
  // Tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    if (failures == 0 && checksDone > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  // Called at a falling edge; returns at the falling edge of the done cycle
  task automatic issue(input mpf_row_t x, output int n);
    reqValid = 1'h1;
    req = '{op: x.op, rd: x.rd, rr: x.rr, k: x.k, absAddr: x.aa, zPtr: x.zp, pc: x.pc};
    check(reqReady, 1'h1);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
      if (n == 1)
      begin
        reqValid = 1'h0;
        check(reqReady, 1'h0);
      end
    end while (done !== 1'h1 && n < 8);
    check(reqReady, 1'h1);
  endtask : issue

  // =======
  // Main sequence
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    repeat (3000) @(posedge clk);
    failures++;
    stop_test();
  end

  initial
  begin
    sys_rst = 1'h1;
    reqValid = 1'h1;
    req = '{op: OP_PTR_CALL, zPtr: 16'h5555, default: '0};
    e = '0;
    repeat (8) @(negedge clk);
    check({reqReady, done, stackPtr}, 6'h20);
    check(res, '0);
    sys_rst = 1'h0;
    reqValid = 1'h0;
    repeat (2) @(negedge clk);
    check({done, stackPtr}, 5'h00);
    for (int i = 0; i < 16; i++)
    begin
      r = rows[i];
      isMulRow = (r.op <= OP_FRAC_MUL_MIXED);
      issue(r, cyc);
      check(cyc, r.n);
      if (isMulRow)
        {e.prod, e.zFlag, e.cFlag} = {r.want, r.zc};
      else
        e.pc = r.want;
      e.pcLoad = !isMulRow;
      e.prodWe = isMulRow;
      e.flagWe = isMulRow;
      e.gieSet = (r.op == OP_IRQ_RETURN);
      check(res, e);
      check(stackPtr, r.sp);
    end
    @(negedge clk);
    check(done, 1'h0);
    check(res, e);
    issue(rows[9], cyc);
    check(stackPtr, 4'h1);
    sys_rst = 1'h1;
    @(negedge clk);
    check({done, stackPtr}, 5'h00);
    check(res, '0);
    sys_rst = 1'h0;
    stop_test();
  end
endmodule : mpf_tb_top
`default_nettype wire
